// *** core/tad_pkg.sv ***
// Shared constants and types for the T1/J1 receive alarm detector
`default_nettype none
package tad_pkg;
	// Window timing: 40 ms fixed windows at the 125 MHz mclk
	localparam int unsigned CLK_HZ = 125_000_000;
	localparam int unsigned WINDOW_MS = 40;
	localparam int unsigned WINDOW_CYCLES = CLK_HZ / 1000 * WINDOW_MS;

	// Register indices; byte address is four times the index
	localparam logic [9:0] IDX_ALARM_STATE = 10'h0b9;
	localparam logic [9:0] IDX_IRQ_ENABLES = 10'h0ba;
	localparam logic [9:0] IDX_CHANGE_FLAGS = 10'h0bb;
	localparam logic [9:0] IDX_FRAME_LOSS_DECL = 10'h0bc;
	localparam logic [9:0] IDX_FRAME_LOSS_CLR = 10'h0bd;
	localparam logic [9:0] IDX_REMOTE_DECL = 10'h0be;
	localparam logic [9:0] IDX_REMOTE_CLR = 10'h0bf;
	localparam logic [9:0] IDX_ALL_ONES_DECL = 10'h0c0;
	localparam logic [9:0] IDX_ALL_ONES_CLR = 10'h0c1;
	localparam logic [9:0] IDX_LINE_FORMAT = 10'h0f8;

	// Bit positions shared by state, enable and change-flag registers
	localparam int unsigned BIT_FRAME_LOSS = 0;
	localparam int unsigned BIT_REMOTE = 1;
	localparam int unsigned BIT_ALL_ONES = 2;
	localparam int unsigned ALARM_COUNT = 3;

	// Reset values
	localparam logic [7:0] THRESHOLD_RST = 8'h01;
	localparam logic [2:0] ENABLES_RST = 3'h0;

	// Per-window criteria
	localparam logic [7:0] SLC96_ONES_MIN = 8'h4d;
	localparam logic [7:0] ESF_PATTERN_MAX = 8'h07;
	localparam logic [15:0] ESF_PATTERN = 16'hff00;
	localparam logic [7:0] DM_ONES_MIN = 8'h04;
	localparam logic [7:0] J1SF_ZEROS_MIN = 8'h04;
	localparam logic [7:0] J1ESF_ZEROS_MIN = 8'h03;
	localparam logic [7:0] ALL_ONES_ZEROS_MIN = 8'h3d;

	// Line framing format
	typedef enum logic [2:0] {
		FMT_T1_SF,
		FMT_T1_ESF,
		FMT_T1_DM,
		FMT_SLC96,
		FMT_J1_SF,
		FMT_J1_ESF
	} tad_fmt_t;
	localparam tad_fmt_t FORMAT_RST = FMT_T1_ESF;
endpackage
`default_nettype wire

// *** core/tad_persist_if.sv ***
// Window tick, conditions and thresholds for one alarm's persistence counter
`default_nettype none
interface tad_persist_if;
	logic tick;
	logic declCond;
	logic clearCond;
	logic [7:0] declN;
	logic [7:0] clearM;
	logic alarm;
	modport owner (output tick, declCond, clearCond, declN, clearM,
		input alarm);
	modport counter (input tick, declCond, clearCond, declN, clearM,
		output alarm);
endinterface
`default_nettype wire

// *** core/tad_persist.sv ***
// Declare/clear persistence counter for one alarm
`default_nettype none
module tad_persist (
	input wire logic mclk,
	input wire logic reset,
	tad_persist_if.counter pif
);
	typedef struct packed {
		logic alarm;
		logic [7:0] count;
	} tad_persist_st_t;

	tad_persist_st_t st_r;
	tad_persist_st_t st_nxt;
	logic [8:0] target;
	logic cond;

	// Count windows that agree with the pending change; any other restarts
	always_comb begin
		st_nxt = st_r;
		target = st_r.alarm ? {1'b0, pif.clearM} : {1'b0, pif.declN};
		if (target == 9'h000) begin
			target = 9'h001; // A zero threshold acts as one window
		end
		cond = st_r.alarm ? pif.clearCond : pif.declCond;
		if (pif.tick) begin
			if (cond) begin
				if ({1'b0, st_r.count} + 9'h001 >= target) begin
					st_nxt.alarm = ~st_r.alarm;
					st_nxt.count = 8'h00;
				end else begin
					st_nxt.count = st_r.count + 8'h01;
				end
			end else begin
				st_nxt.count = 8'h00;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pif.alarm = st_r.alarm;
endmodule
`default_nettype wire

// *** core/tad_win_stats.sv ***
// Per-window bit statistics for remote (yellow) and all-ones (blue) alarms
`default_nettype none
module tad_win_stats (
	input wire logic mclk,
	input wire logic reset,
	input wire logic tick,
	input wire tad_pkg::tad_fmt_t format,
	input wire logic bitValid,
	input wire logic bitValue,
	input wire logic markDl,
	input wire logic markChBit2,
	input wire logic markYBit,
	input wire logic markF12,
	output logic remoteCond,
	output logic allOnesCond
);
	typedef struct packed {
		logic [15:0] dlShift;
		logic [7:0] selCount;
		logic [7:0] patCount;
		logic [7:0] zeroCount;
	} tad_stats_st_t;

	tad_stats_st_t st_r;
	tad_stats_st_t st_nxt;
	logic selHit;
	logic [15:0] dlNext;
	logic patHit;

	// Which marked bit and polarity the format watches
	always_comb begin
		selHit = 1'b0;
		unique case (format)
			tad_pkg::FMT_SLC96: selHit = markChBit2 & bitValue;
			tad_pkg::FMT_T1_DM: selHit = markYBit & bitValue;
			tad_pkg::FMT_J1_SF: selHit = markF12 & ~bitValue;
			tad_pkg::FMT_J1_ESF: selHit = markDl & ~bitValue;
			default: selHit = 1'b0;
		endcase
		selHit = selHit & bitValid;
		dlNext = {st_r.dlShift[14:0], bitValue};
		patHit = bitValid & markDl & (dlNext == tad_pkg::ESF_PATTERN);
	end

	// Judge the ending window from counts held so far
	always_comb begin
		remoteCond = 1'b0;
		unique case (format)
			tad_pkg::FMT_SLC96:
				remoteCond = st_r.selCount < tad_pkg::SLC96_ONES_MIN;
			tad_pkg::FMT_T1_ESF:
				remoteCond = st_r.patCount > tad_pkg::ESF_PATTERN_MAX;
			tad_pkg::FMT_T1_DM:
				remoteCond = st_r.selCount < tad_pkg::DM_ONES_MIN;
			tad_pkg::FMT_J1_SF:
				remoteCond = st_r.selCount < tad_pkg::J1SF_ZEROS_MIN;
			tad_pkg::FMT_J1_ESF:
				remoteCond = st_r.selCount < tad_pkg::J1ESF_ZEROS_MIN;
			default: remoteCond = 1'b0;
		endcase
		allOnesCond = st_r.zeroCount < tad_pkg::ALL_ONES_ZEROS_MIN;
	end

	// Saturating counters; a tick restarts them with the current bit
	always_comb begin
		st_nxt = st_r;
		if (bitValid && markDl) begin
			st_nxt.dlShift = dlNext;
		end
		if (tick) begin
			st_nxt.selCount = {7'h00, selHit};
			st_nxt.patCount = {7'h00, patHit};
			st_nxt.zeroCount = {7'h00, bitValid & ~bitValue};
		end else begin
			if (selHit && st_r.selCount != 8'hff) begin
				st_nxt.selCount = st_r.selCount + 8'h01;
			end
			if (patHit && st_r.patCount != 8'hff) begin
				st_nxt.patCount = st_r.patCount + 8'h01;
			end
			if (bitValid && !bitValue && st_r.zeroCount != 8'hff) begin
				st_nxt.zeroCount = st_r.zeroCount + 8'h01;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (reset) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end
endmodule
`default_nettype wire

// *** core/tad_alarm_detector.sv ***
// T1/J1 receive alarm detector with classic Wishbone register slave
//
// Added by the designer: the Wishbone register port.
`default_nettype none
// Summary of operation
// - Any change of an alarm state sets its change flag.
// - Change flags hold until software writes one; zero leaves them.
// - Interrupt output low while any flag and its enable are both one.
// - Frame-loss alarm declares after N windows of lost synchronization.
// - SLC-96: under 77 ones on channel bit 2 per window.
// - T1 ESF: over 7 ff00 patterns on data-link bits per window.
// - T1 DM: under 4 ones on channel-24 bit 6 per window.
// - J1 SF: under 4 zeros on frame-12 F-bit per window.
// - J1 ESF: under 3 zeros on data-link bits per window.
// - Remote alarm clears after M windows meeting the clear condition.
// - All-ones alarm declares after N windows with under 61 zeros.
// - All-ones alarm clears after M windows meeting the clear condition.
// - Remote alarm windows count only while framer reports synchronization.
module tad_alarm_detector #(
	parameter int unsigned WIN_CYCLES = tad_pkg::WINDOW_CYCLES
) (
	input wire logic mclk,
	input wire logic reset,
	// Register bus, classic single cycle
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [11:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Receive framer, same clock as the bus
	input wire logic frameSync,
	input wire logic bitValid,
	input wire logic bitValue,
	input wire logic markDl,
	input wire logic markChBit2,
	input wire logic markYBit,
	input wire logic markF12,
	// Alarm levels and interrupt, all registered
	output logic frameLossAlarm,
	output logic remoteAlarm,
	output logic allOnesAlarm,
	output logic alarmIrqN
);
	// Window counter width and its last count
	localparam int unsigned WW = $clog2(WIN_CYCLES + 1);
	localparam logic [WW-1:0] WIN_LAST = WW'(WIN_CYCLES - 1);
	localparam int unsigned NA = tad_pkg::ALARM_COUNT;

	// All block state in one word, registered once per edge
	typedef struct packed {
		// Bus answer and captured read word
		logic ack;
		logic [31:0] readData;
		// Interrupt pin, alarm view and software bits
		logic irqN;
		logic [NA-1:0] alarmSeen;
		logic [NA-1:0] changeFlags;
		logic [NA-1:0] irqEnables;
		// Persistence thresholds in windows, one pair per alarm
		logic [7:0] frameLossDeclN;
		logic [7:0] frameLossClearM;
		logic [7:0] remoteDeclN;
		logic [7:0] remoteClearM;
		logic [7:0] allOnesDeclN;
		logic [7:0] allOnesClearM;
		// Line format and the window in progress
		tad_pkg::tad_fmt_t format;
		logic sawSync;
		logic sawLoss;
		logic [WW-1:0] winCount;
	} tad_top_st_t;

	tad_top_st_t st_r;
	tad_top_st_t st_nxt;

	// One bundle per alarm between this block and its counter
	tad_persist_if frameLossIf ();
	tad_persist_if remoteIf ();
	tad_persist_if allOnesIf ();

	// Window, condition and alarm helpers
	logic winTick;
	logic remoteCond;
	logic allOnesCond;
	logic [NA-1:0] alarmNow;
	logic [NA-1:0] changed;
	logic [NA-1:0] flagsAfter;
	// Bus decode helpers
	logic request;
	logic commit;
	logic [9:0] regIndex;
	logic [31:0] readMux;
	logic lostWhole;
	logic heldWhole;

	// Free-running 40 ms window boundary. Windows are fixed, not sliding:
	// a condition that starts mid-window is judged only from the next
	// full window on, so declare and clear times carry up to one window
	// of slack beyond N or M windows.
	assign winTick = (st_r.winCount == WIN_LAST);

	// Synchronization seen over the window that ends at this tick.
	// The tick cycle itself is folded in here because the history
	// registers are cleared at the tick and would miss it.
	// A window with both states counts for neither direction.
	assign lostWhole = ~(st_r.sawSync | frameSync);
	assign heldWhole = ~(st_r.sawLoss | ~frameSync);

	// Frame-loss persistence: declare on lost windows, clear on held ones
	assign frameLossIf.tick = winTick;
	assign frameLossIf.declCond = lostWhole;
	assign frameLossIf.clearCond = heldWhole;
	assign frameLossIf.declN = st_r.frameLossDeclN;
	assign frameLossIf.clearM = st_r.frameLossClearM;

	// Remote windows are skipped unless in sync for the whole window
	// Skipped windows neither advance nor restart the count
	assign remoteIf.tick = winTick & heldWhole;
	assign remoteIf.declCond = remoteCond;
	assign remoteIf.clearCond = ~remoteCond;
	assign remoteIf.declN = st_r.remoteDeclN;
	assign remoteIf.clearM = st_r.remoteClearM;

	// All-ones is judged regardless of synchronization
	// An unframed all-ones signal must still raise it
	assign allOnesIf.tick = winTick;
	assign allOnesIf.declCond = allOnesCond;
	assign allOnesIf.clearCond = ~allOnesCond;
	assign allOnesIf.declN = st_r.allOnesDeclN;
	assign allOnesIf.clearM = st_r.allOnesClearM;

	// Frame-loss declare and clear counter
	tad_persist frameLossPersist (
		.mclk(mclk),
		.reset(reset),
		.pif(frameLossIf)
	);

	// Remote alarm declare and clear counter
	tad_persist remotePersist (
		.mclk(mclk),
		.reset(reset),
		.pif(remoteIf)
	);

	// All-ones alarm declare and clear counter
	tad_persist allOnesPersist (
		.mclk(mclk),
		.reset(reset),
		.pif(allOnesIf)
	);

	// Bit statistics feeding the remote and all-ones judgements
	tad_win_stats winStats (
		.mclk(mclk),
		.reset(reset),
		.tick(winTick),
		.format(st_r.format),
		.bitValid(bitValid),
		.bitValue(bitValue),
		.markDl(markDl),
		.markChBit2(markChBit2),
		.markYBit(markYBit),
		.markF12(markF12),
		.remoteCond(remoteCond),
		.allOnesCond(allOnesCond)
	);

	// Gather live alarm states in register bit order
	// Counter outputs, one cycle ahead of the state register
	always_comb begin
		alarmNow = '0;
		alarmNow[tad_pkg::BIT_FRAME_LOSS] = frameLossIf.alarm;
		alarmNow[tad_pkg::BIT_REMOTE] = remoteIf.alarm;
		alarmNow[tad_pkg::BIT_ALL_ONES] = allOnesIf.alarm;
	end

	// Bus decode; one wait state, so ack comes the cycle after the request
	// Commit needs ack already high, so a write lands exactly once,
	// at the edge where the master sees ack.
	assign request = wb_cyc_i & wb_stb_i;
	assign commit = request & st_r.ack;
	assign regIndex = wb_adr_i[11:2];

	// Read multiplexer; unmapped indices read as zero
	// Captured at request time, so the word stands through ack
	always_comb begin
		readMux = 32'h0000_0000;
		unique case (regIndex)
			tad_pkg::IDX_ALARM_STATE:
				readMux[NA-1:0] = st_r.alarmSeen;
			tad_pkg::IDX_IRQ_ENABLES:
				readMux[NA-1:0] = st_r.irqEnables;
			tad_pkg::IDX_CHANGE_FLAGS:
				readMux[NA-1:0] = st_r.changeFlags;
			tad_pkg::IDX_FRAME_LOSS_DECL:
				readMux[7:0] = st_r.frameLossDeclN;
			tad_pkg::IDX_FRAME_LOSS_CLR:
				readMux[7:0] = st_r.frameLossClearM;
			tad_pkg::IDX_REMOTE_DECL:
				readMux[7:0] = st_r.remoteDeclN;
			tad_pkg::IDX_REMOTE_CLR:
				readMux[7:0] = st_r.remoteClearM;
			tad_pkg::IDX_ALL_ONES_DECL:
				readMux[7:0] = st_r.allOnesDeclN;
			tad_pkg::IDX_ALL_ONES_CLR:
				readMux[7:0] = st_r.allOnesClearM;
			tad_pkg::IDX_LINE_FORMAT:
				readMux[2:0] = st_r.format;
			default:
				readMux = 32'h0000_0000;
		endcase
	end

	// Next-state logic for bus, registers, flags and window tracking
	// Every field starts from its held value, so each path assigns all
	always_comb begin
		st_nxt = st_r;
		changed = alarmNow ^ st_r.alarmSeen;
		flagsAfter = st_r.changeFlags;

		// Ack drops the cycle after it was given
		st_nxt.ack = request & ~st_r.ack;
		if (request && !st_r.ack) begin
			st_nxt.readData = readMux;
		end

		// Writes land only at the edge where the master sees ack
		if (commit && wb_we_i && wb_sel_i[0]) begin
			unique case (regIndex)
				tad_pkg::IDX_IRQ_ENABLES:
					st_nxt.irqEnables = wb_dat_i[NA-1:0];
				tad_pkg::IDX_CHANGE_FLAGS:
					flagsAfter = st_r.changeFlags & ~wb_dat_i[NA-1:0];
				tad_pkg::IDX_FRAME_LOSS_DECL:
					st_nxt.frameLossDeclN = wb_dat_i[7:0];
				tad_pkg::IDX_FRAME_LOSS_CLR:
					st_nxt.frameLossClearM = wb_dat_i[7:0];
				tad_pkg::IDX_REMOTE_DECL:
					st_nxt.remoteDeclN = wb_dat_i[7:0];
				tad_pkg::IDX_REMOTE_CLR:
					st_nxt.remoteClearM = wb_dat_i[7:0];
				tad_pkg::IDX_ALL_ONES_DECL:
					st_nxt.allOnesDeclN = wb_dat_i[7:0];
				tad_pkg::IDX_ALL_ONES_CLR:
					st_nxt.allOnesClearM = wb_dat_i[7:0];
				tad_pkg::IDX_LINE_FORMAT:
					st_nxt.format = tad_pkg::tad_fmt_t'(wb_dat_i[2:0]);
				default: ;
			endcase
		end

		// A change in the same cycle as a clear still sets the flag
		// so software never loses a transition it has not yet seen
		st_nxt.changeFlags = flagsAfter | changed;
		st_nxt.alarmSeen = alarmNow;

		// Registered so the pin never glitches on decode
		// Uses next values so the pin follows flags without a lag
		st_nxt.irqN = ~|(st_nxt.changeFlags & st_nxt.irqEnables);

		// Window counter and sync history
		// History restarts at each tick; the tick cycle is judged above
		if (winTick) begin
			st_nxt.winCount = '0;
			st_nxt.sawSync = 1'b0;
			st_nxt.sawLoss = 1'b0;
		end else begin
			st_nxt.winCount = st_r.winCount + WW'(1);
			st_nxt.sawSync = st_r.sawSync | frameSync;
			st_nxt.sawLoss = st_r.sawLoss | ~frameSync;
		end
	end

	// Reset: pin idle high, thresholds one window, default format
	always_ff @(posedge mclk) begin
		if (reset) begin
			st_r <= '0;
			st_r.irqN <= 1'b1;
			st_r.irqEnables <= tad_pkg::ENABLES_RST;
			st_r.frameLossDeclN <= tad_pkg::THRESHOLD_RST;
			st_r.frameLossClearM <= tad_pkg::THRESHOLD_RST;
			st_r.remoteDeclN <= tad_pkg::THRESHOLD_RST;
			st_r.remoteClearM <= tad_pkg::THRESHOLD_RST;
			st_r.allOnesDeclN <= tad_pkg::THRESHOLD_RST;
			st_r.allOnesClearM <= tad_pkg::THRESHOLD_RST;
			st_r.format <= tad_pkg::FORMAT_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from flops
	// Alarm pins mirror the state register so both agree every cycle
	assign wb_ack_o = st_r.ack;
	assign wb_dat_o = st_r.readData;
	assign alarmIrqN = st_r.irqN;
	assign frameLossAlarm = st_r.alarmSeen[tad_pkg::BIT_FRAME_LOSS];
	assign remoteAlarm = st_r.alarmSeen[tad_pkg::BIT_REMOTE];
	assign allOnesAlarm = st_r.alarmSeen[tad_pkg::BIT_ALL_ONES];
endmodule
`default_nettype wire

// *** verification/tad_framer_model.sv ***
// Receive framer stand-in: sync level and a qualified bit stream
`default_nettype none
module tad_framer_model (
	input wire logic mclk,
	input wire logic reset,
	input wire logic syncOn,
	input wire logic [1:0] pat,
	output logic frameSync,
	output logic bitValid,
	output logic bitValue,
	output logic markDl,
	output logic markChBit2,
	output logic markYBit,
	output logic markF12
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] slot;
	logic [3:0] pos;
	// Slot counter; one idle slot in eight
	always_ff @(posedge mclk) begin
		if (reset) begin
			slot <= 3'h0;
			pos <= 4'h0;
		end else begin
			slot <= slot + 3'h1;
			if (bitValid)
				pos <= pos + 4'h1;
		end
	end
	// Idle slots carry junk so unqualified sampling shows
	always_comb begin
		bitValid = slot != 3'h7;
		frameSync = syncOn;
		case (pat)
			2'h0: bitValue = 1'b1;
			2'h1: bitValue = 1'b0;
			default: bitValue = !pos[3]; // ff00, MSB first
		endcase
		if (!bitValid)
			bitValue = pos[0];
		markDl = bitValid | pos[1];
		markChBit2 = markDl;
		markYBit = markDl;
		markF12 = markDl;
	end
endmodule
`default_nettype wire

// *** verification/tad_alarm_detector_properties.sv ***
// Checker for the alarm detector bus answer and alarm outputs
`default_nettype none
module tad_alarm_detector_properties #(
	parameter int unsigned WIN_CYCLES = 64
) (
	input wire logic mclk,
	input wire logic reset,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic wb_ack_o,
	input wire logic frameSync,
	input wire logic frameLossAlarm,
	input wire logic remoteAlarm,
	input wire logic allOnesAlarm,
	input wire logic alarmIrqN
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] al;
	logic wrAck;
	// Alarm vector, bit order as in the state register
	assign al = {allOnesAlarm, remoteAlarm, frameLossAlarm};
	// Write answered at this edge
	assign wrAck = wb_ack_o & wb_we_i;
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	// Bus: one answer a cycle after a new request, never unasked
	property p_ack_resp;
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
	endproperty
	a_ack_resp: assert property (p_ack_resp) else $error("ack late");
	property p_ack_pulse;
		wb_ack_o |=> !wb_ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
	property p_ack_idle;
		!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
	endproperty
	a_ack_idle: assert property (p_ack_idle) else $error("stray ack");
	// Alarm edges against the sync level of the window's last cycle
	property p_red_rise;
		$rose(frameLossAlarm) |-> !$past(frameSync, 2);
	endproperty
	a_red_rise: assert property (p_red_rise) else $error("red rise");
	property p_red_fall;
		$fell(frameLossAlarm) |-> $past(frameSync, 2);
	endproperty
	a_red_fall: assert property (p_red_fall) else $error("red fall");
	property p_yel_sync;
		$rose(remoteAlarm) |-> $past(frameSync, 2);
	endproperty
	a_yel_sync: assert property (p_yel_sync) else $error("yel sync");
	// States hold for at least eight cycles after each move
	property p_pace;
		$changed(al) |=> $stable(al)[*8];
	endproperty
	a_pace: assert property (p_pace) else $error("alarm pace");
	// Pin and flags move at the same edge as the write or the alarm view
	property p_irq_rise;
		$rose(alarmIrqN) |-> $past(wrAck);
	endproperty
	a_irq_rise: assert property (p_irq_rise) else $error("irq rise");
	property p_irq_fall;
		$fell(alarmIrqN) |-> al != $past(al) || $past(wrAck);
	endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq fall");
	c_red: cover property ($rose(frameLossAlarm));
	c_yel: cover property ($rose(remoteAlarm));
	c_blue: cover property ($rose(allOnesAlarm));
	c_irq: cover property ($fell(alarmIrqN));
endmodule
bind tad_alarm_detector tad_alarm_detector_properties #(
	.WIN_CYCLES(WIN_CYCLES)) u_props (.*);
`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking bench for the T1/J1 receive alarm detector
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int W = 256;
	localparam logic [7:0] THR [6] = '{8'h02, 8'h03, 8'h01, 8'h02, 8'h03,
		8'h01};
	localparam logic [1:0] DECL [6] = '{2'h0, 2'h2, 2'h1, 2'h1, 2'h0, 2'h0};
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [11:0] wb_adr_i = 12'h000;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
	logic wb_ack_o, frameSync, bitValid, bitValue, markDl, markChBit2;
	logic markYBit, markF12, frameLossAlarm, remoteAlarm, allOnesAlarm;
	logic alarmIrqN;
	logic syncOn = 1'b1;
	logic [1:0] pat = 2'h1;
	logic [2:0] al;
	int miscompares = 0;
	int comparisons = 0;
	tad_alarm_detector #(.WIN_CYCLES(W)) DUT (.*);
	tad_framer_model framer (.*);
	assign al = {allOnesAlarm, remoteAlarm, frameLossAlarm};
	// Free-running clock
	initial begin
		forever #4 mclk = ~mclk;
	end
	task automatic results();
		if (miscompares == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("FAIL %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One classic cycle; the watchdog bounds the wait for ack
	task automatic wb(input logic w, input logic [9:0] i,
		input logic [7:0] d, input logic [3:0] s);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= {i, 2'b00};
		wb_sel_i <= s;
		wb_dat_i <= {24'h0, d};
		do @(posedge mclk); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic wr(input logic [9:0] i, input logic [7:0] d);
		wb(1'b1, i, d, 4'h1);
	endtask
	task automatic rd(input logic [9:0] i, input logic [7:0] e);
		wb(1'b0, i, 8'h00, 4'hf);
		chk(q, {24'h0, e});
	endtask
	// Still at !v short of n windows (if lo), at v after n full windows
	task automatic persist(input int b, input logic v, input int n,
		input bit lo);
		repeat (n * W - 4) @(posedge mclk);
		if (lo)
			chk(al[b], !v);
		repeat (W + 12) @(posedge mclk);
		chk(al[b], v);
	endtask
	// Watchdog, well beyond the planned run
	initial begin
		repeat (40000) @(posedge mclk);
		miscompares++;
		results();
	end
	initial begin
		repeat (20) @(posedge mclk);
		reset <= 1'b0;
		@(posedge mclk);
		// Reset values, read-only state, unmapped index, lane 0
		for (int i = 'h0b9; i <= 'h0c1; i++)
			rd(i[9:0], (i > 'h0bb) ? 8'h01 : 8'h00);
		rd(10'h0f8, 8'h01);
		wr(10'h010, 8'h5a);
		rd(10'h010, 8'h00);
		wr(10'h0b9, 8'hff);
		rd(10'h0b9, 8'h00);
		for (int i = 0; i < 6; i++)
			wr(10'h0bc + i[9:0], THR[i]);
		wb(1'b1, 10'h0bc, 8'h55, 4'he);
		for (int i = 0; i < 6; i++)
			rd(10'h0bc + i[9:0], THR[i]);
		wr(10'h0ba, 8'h07);
		rd(10'h0ba, 8'h07);
		// Sync lost under a remote pattern: only frame loss counts
		pat <= 2'h2;
		syncOn <= 1'b0;
		persist(0, 1'b1, 2, 1'b1);
		chk(al, 3'h1);
		rd(10'h0b9, 8'h01);
		rd(10'h0bb, 8'h01);
		chk(alarmIrqN, 1'b0);
		wr(10'h0bb, 8'h00);
		rd(10'h0bb, 8'h01);
		wr(10'h0bb, 8'h01);
		@(posedge mclk);
		chk(alarmIrqN, 1'b1);
		// Clear with the enable masked, then unmasked
		wr(10'h0ba, 8'h06);
		pat <= 2'h1;
		syncOn <= 1'b1;
		persist(0, 1'b0, 3, 1'b1);
		rd(10'h0bb, 8'h01);
		chk(alarmIrqN, 1'b1);
		wr(10'h0ba, 8'h07);
		@(posedge mclk);
		chk(alarmIrqN, 1'b0);
		// All-ones alarm; both of its moves and the red clear are flagged
		pat <= 2'h0;
		persist(2, 1'b1, 3, 1'b0);
		pat <= 2'h1;
		persist(2, 1'b0, 1, 1'b0);
		rd(10'h0bb, 8'h05);
		wr(10'h0bb, 8'h05);
		@(posedge mclk);
		chk(alarmIrqN, 1'b1);
		// Each format with its own remote criterion
		for (int f = 1; f < 6; f++) begin
			wr(10'h0f8, f[7:0]);
			pat <= DECL[f];
			persist(1, 1'b1, 1, 1'b0);
			pat <= (f > 3) ? 2'h1 : 2'h0;
			persist(1, 1'b0, 2, 1'b0);
		end
		// Plain superframe has no remote criterion
		wr(10'h0f8, 8'h00);
		pat <= 2'h2;
		repeat (3 * W) @(posedge mclk);
		chk(remoteAlarm, 1'b0);
		results();
	end
endmodule
`default_nettype wire
